/* slave_exec.sv */
`timescale 1ns/10ps
module slave_exec
(
  input wire logic clk,              // Instruction cycle clock
  input wire logic rst,              // Synchronous reset, active high
  input wire logic ce,               // Clock enable, freezes all state when low
  input wire logic [7:0] rom_data,   // Program memory byte at rom_addr, same cycle
  input wire logic host_write,       // Host writes host_data_buffer input, pulse
  input wire logic [7:0] host_wdata, // Host write data
  input wire logic host_read,        // Host reads output buffer, pulse
  input wire logic t1_pin,           // Counter input pin, asynchronous
  output logic [11:0] rom_addr,      // Program memory address
  output logic [11:0] pc,            // Program counter
  output logic [7:0] acc,            // Accumulator
  output logic carry,                // Carry flag
  output logic [7:0] host_rdata,     // Output buffer to host
  output logic [7:0] host_status_register, // Status seen by host
  output logic input_full_flag,      // Input buffer full
  output logic output_full_flag,     // Output buffer full
  output logic timer_flag,           // Timer overflow flag
  output logic timer_count_interrupt, // Timer interrupt request
  output logic [7:0] timer_value,    // Timer/counter value
  output logic suspended             // Core is in suspend
);
  localparam int RAM_DEPTH = 64;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    exec_pkg::phase_e phase;
    logic [7:0] op;
    logic [11:0] pc;
    logic [11:0] rom_addr;
    logic [7:0] acc;
    logic carry;
    logic bank;
    logic [RAM_DEPTH-1:0][7:0] ram;
    logic [7:0] in_buffer;
    logic [7:0] out_buffer;
    logic in_full;
    logic out_full;
    logic [3:0] status_hi;
    logic [7:0] timer;
    logic [4:0] prescale;
    logic tmr_run;
    logic cnt_run;
    logic tf;
    logic tirq_en;
    logic tirq;
    logic jt_taken;
    logic [2:0] t1_sync;
    logic t1_level;
  } state_s;

  localparam state_s STATE_RESET = '{
    phase: exec_pkg::PH_EXEC, pc: exec_pkg::PC_RESET, rom_addr: exec_pkg::PC_RESET,
    acc: exec_pkg::ACC_RESET, default: '0};

  state_s s_reg;
  state_s s_next;
  logic [5:0] reg_i;
  logic [5:0] ind_i;
  logic [5:0] ind2_i;
  logic tick;
  logic ovf;
  logic t1_fall;

  function automatic logic [5:0] reg_idx(input logic bank, input logic [2:0] r);
    reg_idx = bank ? (exec_pkg::BANK1_BASE | {3'b000, r}) : {3'b000, r};
  endfunction : reg_idx

  // Register and pointer addresses for the opcode now on the bus; ind2_i is the pointer for the latched opcode
  assign reg_i = reg_idx(s_reg.bank, rom_data[2:0]);
  assign ind_i = s_reg.ram[reg_idx(s_reg.bank, {2'b00, rom_data[0]})][5:0];
  assign ind2_i = s_reg.ram[reg_idx(s_reg.bank, {2'b00, s_reg.op[0]})][5:0];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_next = s_reg;
    tick = 1'b0;
    ovf = 1'b0;
    // Pin filter: a level counts once stages two and three agree
    s_next.t1_sync = {s_reg.t1_sync[1:0], t1_pin};
    t1_fall = s_reg.t1_level && (s_reg.t1_sync[1] == s_reg.t1_sync[2]) && !s_reg.t1_sync[1];
    if (s_reg.t1_sync[1] == s_reg.t1_sync[2])
      s_next.t1_level = s_reg.t1_sync[1];
    // Timer runs from the prescaler, counter from the filtered pin
    if (s_reg.tmr_run)
    begin
      s_next.prescale = s_reg.prescale + 5'h01;
      tick = (s_reg.prescale == exec_pkg::TIMER_PRESCALE_LAST);
    end
    if (s_reg.cnt_run)
      tick = t1_fall;
    if (tick)
    begin
      s_next.timer = s_reg.timer + 8'h01;
      ovf = (s_reg.timer == 8'hFF);
    end
    // Host reading the output buffer empties it
    if (host_read)
      s_next.out_full = 1'b0;
    unique case (s_reg.phase)
      exec_pkg::PH_EXEC:
      begin
        s_next.pc = s_reg.pc + 12'h001;
        s_next.rom_addr = s_reg.pc + 12'h001;
        s_next.op = rom_data;
        // Family encoding, unknown codes run as one-cycle no-ops
        casez (rom_data)
          exec_pkg::OP_FLAG_BRANCH:
          begin
            s_next.jt_taken = s_reg.tf;
            s_next.tf = 1'b0;
            s_next.phase = exec_pkg::PH_SECOND;
          end
          exec_pkg::OP_MOV_A_IMM, {7'b1011000, 1'b?}:
            s_next.phase = exec_pkg::PH_SECOND;
          {7'b0010000, 1'b?}:
          begin
            s_next.acc = s_reg.ram[ind_i];
            s_next.ram[ind_i] = s_reg.acc;
          end
          {5'b00101, 3'b???}:
          begin
            s_next.acc = s_reg.ram[reg_i];
            s_next.ram[reg_i] = s_reg.acc;
          end
          {7'b0011000, 1'b?}:
          begin
            s_next.acc[3:0] = s_reg.ram[ind_i][3:0];
            s_next.ram[ind_i][3:0] = s_reg.acc[3:0];
          end
          exec_pkg::OP_PAGE_READ:
          begin
            s_next.rom_addr = {s_reg.pc[11:8], s_reg.acc};
            s_next.phase = exec_pkg::PH_SECOND;
          end
          exec_pkg::OP_FIXED_PAGE_READ:
          begin
            s_next.rom_addr = {exec_pkg::FIXED_PAGE, s_reg.acc};
            s_next.phase = exec_pkg::PH_SECOND;
          end
          exec_pkg::OP_STATUS_COPY:
            s_next.status_hi = s_reg.acc[7:4];
          exec_pkg::OP_ROTATE_CARRY:
          begin
            s_next.acc = {s_reg.acc[6:0], s_reg.carry};
            s_next.carry = s_reg.acc[7];
          end
          exec_pkg::OP_BUFFER_IN:
          begin
            s_next.acc = s_reg.in_buffer;
            s_next.in_full = 1'b0;
          end
          exec_pkg::OP_BUFFER_OUT:
          begin
            s_next.out_buffer = s_reg.acc;
            s_next.out_full = 1'b1;
          end
          exec_pkg::OP_TIMER_IRQ_ON:
            s_next.tirq_en = 1'b1;
          exec_pkg::OP_TIMER_IRQ_OFF:
            s_next.tirq_en = 1'b0;
          exec_pkg::OP_STRT_T:
          begin
            s_next.tmr_run = 1'b1;
            s_next.cnt_run = 1'b0;
            s_next.prescale = 5'h00;
          end
          exec_pkg::OP_STRT_CNT:
          begin
            s_next.cnt_run = 1'b1;
            s_next.tmr_run = 1'b0;
          end
          exec_pkg::OP_STOP_TCNT:
          begin
            s_next.tmr_run = 1'b0;
            s_next.cnt_run = 1'b0;
          end
          exec_pkg::OP_MOV_T_A:
          begin
            s_next.timer = s_reg.acc;                                      // Load beats a tick
            ovf = 1'b0;
          end
          exec_pkg::OP_MOV_A_T:
            s_next.acc = s_reg.timer;
          exec_pkg::OP_SEL_RB0:
            s_next.bank = 1'b0;
          exec_pkg::OP_SEL_RB1:
            s_next.bank = 1'b1;
          exec_pkg::OP_SUSPEND:
          begin
            s_next.pc = s_reg.pc;
            s_next.rom_addr = s_reg.pc;
            s_next.phase = exec_pkg::PH_SECOND;
          end
          default:
            s_next.op = exec_pkg::OP_NOP;
        endcase
      end
      exec_pkg::PH_SECOND:
      begin
        s_next.phase = exec_pkg::PH_EXEC;
        s_next.pc = s_reg.pc + 12'h001;
        s_next.rom_addr = s_reg.pc + 12'h001;
        casez (s_reg.op)
          exec_pkg::OP_FLAG_BRANCH:
            if (s_reg.jt_taken)
            begin
              s_next.pc = {s_reg.pc[11:8], rom_data};
              s_next.rom_addr = {s_reg.pc[11:8], rom_data};
            end
          exec_pkg::OP_MOV_A_IMM:
            s_next.acc = rom_data;
          {7'b1011000, 1'b?}:
            s_next.ram[ind2_i] = rom_data;
          exec_pkg::OP_PAGE_READ, exec_pkg::OP_FIXED_PAGE_READ:
          begin
            s_next.acc = rom_data;
            s_next.pc = s_reg.pc;
            s_next.rom_addr = s_reg.pc;
          end
          default:
          begin
            s_next.phase = exec_pkg::PH_SUSPEND;
            s_next.pc = s_reg.pc;
            s_next.rom_addr = s_reg.pc;
          end
        endcase
      end
      exec_pkg::PH_SUSPEND:
      begin
        // Only reset wakes the core; the timer stays frozen too
        s_next.tmr_run = 1'b0;
        s_next.cnt_run = 1'b0;
        ovf = 1'b0;
        s_next.timer = s_reg.timer;
        s_next.prescale = s_reg.prescale;
      end
    endcase
    // Hardware sets win over same-cycle clears
    if (ovf)
      s_next.tf = 1'b1;
    if (host_write)
    begin
      s_next.in_buffer = host_wdata;
      s_next.in_full = 1'b1;
    end
    s_next.tirq = s_next.tirq_en && s_next.tf;
  end

  // State register, held while ce is low
  always_ff @(posedge clk)
  begin
    if (rst)
      s_reg <= STATE_RESET;
    else if (ce)
      s_reg <= s_next;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rom_addr = s_reg.rom_addr;
  assign pc = s_reg.pc;
  assign acc = s_reg.acc;
  assign carry = s_reg.carry;
  assign host_rdata = s_reg.out_buffer;
  assign host_status_register = {s_reg.status_hi, 2'b00, s_reg.in_full, s_reg.out_full};
  assign input_full_flag = s_reg.in_full;
  assign output_full_flag = s_reg.out_full;
  assign timer_flag = s_reg.tf;
  assign timer_count_interrupt = s_reg.tirq;
  assign timer_value = s_reg.timer;
  assign suspended = (s_reg.phase == exec_pkg::PH_SUSPEND);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic exec_now;
  assign exec_now = ce && (s_reg.phase == exec_pkg::PH_EXEC);

  sequence two_steps_s;
    ce ##1 ce;
  endsequence

  tf_branch_a: assert property (exec_now && rom_data == exec_pkg::OP_FLAG_BRANCH && !ovf
    ##1 ce && !ovf |=> !s_reg.tf && s_reg.pc == ($past(s_reg.jt_taken)
    ? {$past(s_reg.pc[11:8]), $past(rom_data)} : $past(s_reg.pc) + 12'h001))
    else $error("timer flag branch wrong");
  digit_swap_a: assert property (exec_now && rom_data[7:1] == 7'b0011000
    |=> s_reg.acc[3:0] == $past(s_reg.ram[ind_i][3:0])
    && s_reg.acc[7:4] == $past(s_reg.acc[7:4]) && s_reg.phase == exec_pkg::PH_EXEC)
    else $error("digit exchange wrong");
  page_read_a: assert property (exec_now && rom_data == exec_pkg::OP_PAGE_READ ##1 ce
    |-> s_reg.rom_addr == {$past(s_reg.pc[11:8]), $past(s_reg.acc)}
    ##1 s_reg.acc == $past(rom_data))
    else $error("page lookup read wrong");
  fixed_page_a: assert property (exec_now && rom_data == exec_pkg::OP_FIXED_PAGE_READ ##1 ce
    |-> s_reg.rom_addr == {exec_pkg::FIXED_PAGE, $past(s_reg.acc)}
    ##1 s_reg.acc == $past(rom_data) && s_reg.phase == exec_pkg::PH_EXEC)
    else $error("fixed page lookup read wrong");
  status_copy_a: assert property (exec_now && rom_data == exec_pkg::OP_STATUS_COPY
    |=> host_status_register[7:4] == $past(s_reg.acc[7:4]))
    else $error("status copy wrong");
  tirq_enable_a: assert property (exec_now && rom_data == exec_pkg::OP_TIMER_IRQ_ON
    |=> s_reg.tirq_en && (timer_count_interrupt == s_reg.tf))
    else $error("timer interrupt enable wrong");
  exchange_ind_a: assert property (exec_now && rom_data[7:1] == 7'b0010000
    |=> s_reg.acc == $past(s_reg.ram[ind_i]) && s_reg.phase == exec_pkg::PH_EXEC)
    else $error("indirect exchange wrong");
  exchange_reg_a: assert property (exec_now && rom_data[7:3] == 5'b00101
    |=> s_reg.ram[$past(reg_i)] == $past(s_reg.acc))
    else $error("register exchange wrong");
  rotate_carry_a: assert property (exec_now && rom_data == exec_pkg::OP_ROTATE_CARRY
    |=> s_reg.acc == {$past(s_reg.acc[6:0]), $past(s_reg.carry)}
    && s_reg.carry == $past(s_reg.acc[7]))
    else $error("rotate through carry wrong");
  store_imm_a: assert property (exec_now && rom_data[7:1] == 7'b1011000 ##1 two_steps_s
    |-> s_reg.ram[$past(ind2_i)] == $past(rom_data) && s_reg.phase == exec_pkg::PH_EXEC)
    else $error("immediate store wrong");
  input_clear_a: assert property (exec_now && rom_data == exec_pkg::OP_BUFFER_IN
    |=> s_reg.in_full == $past(host_write) && s_reg.acc == $past(s_reg.in_buffer))
    else $error("input buffer read wrong");
  output_set_a: assert property (exec_now && rom_data == exec_pkg::OP_BUFFER_OUT
    |=> s_reg.out_full && host_rdata == $past(s_reg.acc))
    else $error("output buffer write wrong");
  suspend_entry_a: assert property (exec_now && rom_data == exec_pkg::OP_SUSPEND ##1 ce
    |-> !suspended ##1 suspended)
    else $error("suspend entry wrong");
endmodule : slave_exec

/* exec_pkg.sv */
package exec_pkg;
  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_BUFFER_OUT = 8'h02;
  localparam logic [7:0] OP_FLAG_BRANCH = 8'h16;
  localparam logic [7:0] OP_ACC_EXCHANGE_IND = 8'h20; // Low bit selects pointer register
  localparam logic [7:0] OP_BUFFER_IN = 8'h22;
  localparam logic [7:0] OP_MOV_A_IMM = 8'h23;
  localparam logic [7:0] OP_TIMER_IRQ_ON = 8'h25;
  localparam logic [7:0] OP_ACC_EXCHANGE_REG = 8'h28; // Low three bits select register
  localparam logic [7:0] OP_DIGIT_EXCHANGE = 8'h30;
  localparam logic [7:0] OP_TIMER_IRQ_OFF = 8'h35;
  localparam logic [7:0] OP_MOV_A_T = 8'h42;
  localparam logic [7:0] OP_STRT_CNT = 8'h45;
  localparam logic [7:0] OP_STRT_T = 8'h55;
  localparam logic [7:0] OP_MOV_T_A = 8'h62;
  localparam logic [7:0] OP_STOP_TCNT = 8'h65;
  localparam logic [7:0] OP_SUSPEND = 8'h82;
  localparam logic [7:0] OP_STATUS_COPY = 8'h90;
  localparam logic [7:0] OP_PAGE_READ = 8'hA3;
  localparam logic [7:0] OP_MOV_IND_IMM = 8'hB0;
  localparam logic [7:0] OP_SEL_RB0 = 8'hC5;
  localparam logic [7:0] OP_SEL_RB1 = 8'hD5;
  localparam logic [7:0] OP_FIXED_PAGE_READ = 8'hE3;
  localparam logic [7:0] OP_ROTATE_CARRY = 8'hF7;
  // ----------------------------------------
  // Layout and counts
  // ----------------------------------------
  localparam logic [3:0] FIXED_PAGE = 4'h3;
  localparam logic [5:0] BANK1_BASE = 6'h18;
  localparam logic [4:0] TIMER_PRESCALE_LAST = 5'h1F;  // Timer ticks every 32 cycles
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  // ----------------------------------------
  // Phases
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    PH_EXEC = 3'b001,
    PH_SECOND = 3'b010,
    PH_SUSPEND = 3'b100
  } phase_e;
endpackage : exec_pkg

/* host_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Host processor on the data bus buffer
// ----------------------------------------
module host_model
(
  input wire logic clk,              // Instruction cycle clock
  input wire logic [7:0] host_rdata, // Output buffer from the device
  output logic host_write,           // Write pulse
  output logic [7:0] host_wdata,     // Write data
  output logic host_read             // Read pulse
);
  // Idle bus: no strobes, data holds a pattern nobody should trust
  initial
  begin
    host_write = 1'b0;
    host_read = 1'b0;
    host_wdata = 8'hA5;
  end
  // One-cycle write pulse, launched at a falling edge
  task automatic send(input logic [7:0] d);
    host_write = 1'b1;
    host_wdata = d;
    @(negedge clk);
    host_write = 1'b0;
    host_wdata = ~d; // Released data must not look like the last byte
  endtask : send
  // Takes the byte first, then pulses read so the full flag drops
  task automatic take(output logic [7:0] d);
    d = host_rdata;
    host_read = 1'b1;
    @(negedge clk);
    host_read = 1'b0;
  endtask : take
endmodule : host_model

/* slave_mcu_instruction_execution_bench.sv */
`timescale 1ns/10ps
module slave_mcu_instruction_execution_bench;
  logic clk, rst, ce, t1_pin, host_write, host_read, carry;
  logic input_full_flag, output_full_flag, timer_flag, timer_count_interrupt, suspended;
  logic [7:0] rom_data, host_wdata, acc, host_rdata, host_status_register, timer_value, got;
  logic [11:0] rom_addr, pc;
  logic [7:0] rom [0:4095];
  int mismatches = 0;
  int cmp_count = 0;
  int n;
  // Program memory answers in the same cycle
  assign rom_data = rom[rom_addr];
  slave_exec uut
  (
    .clk(clk), .rst(rst), .ce(ce), .rom_data(rom_data), .host_write(host_write),
    .host_wdata(host_wdata), .host_read(host_read), .t1_pin(t1_pin), .rom_addr(rom_addr),
    .pc(pc), .acc(acc), .carry(carry), .host_rdata(host_rdata),
    .host_status_register(host_status_register), .input_full_flag(input_full_flag),
    .output_full_flag(output_full_flag), .timer_flag(timer_flag),
    .timer_count_interrupt(timer_count_interrupt), .timer_value(timer_value),
    .suspended(suspended)
  );
  host_model host
  (
    .clk(clk), .host_rdata(host_rdata), .host_write(host_write),
    .host_wdata(host_wdata), .host_read(host_read)
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic compare(input logic [11:0] g, input logic [11:0] e);
    cmp_count++;
    if (g !== e)
    begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      mismatches++;
    end
  endtask : compare
  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask : step
  // Clears memory to NOPs so stray fetches do nothing
  task automatic clear_rom();
    for (int i = 0; i < 4096; i++) rom[i] = 8'h00;
  endtask : clear_rom
  // One reset edge, then the first opcode runs at the next rising edge
  task automatic restart();
    rst = 1'b1;
    step(1);
    rst = 1'b0;
  endtask : restart
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Rotate twice, with a clock-enable stall between the two
  task automatic test_rotate();
    clear_rom();
    rom[0] = 8'h23; rom[1] = 8'h81; rom[2] = 8'hF7; rom[3] = 8'hF7;
    restart();
    step(3);
    compare({4'h0, acc}, 12'h002);
    compare({11'h000, carry}, 12'h001);
    ce = 1'b0;
    step(3);
    compare(pc, 12'h003); // Frozen while disabled
    ce = 1'b1;
    step(1);
    compare({3'h0, carry, acc}, 12'h005);
    compare(pc, 12'h004);
  endtask : test_rotate
  // Register, memory and digit exchanges around an immediate store
  task automatic test_exchange();
    clear_rom();
    rom[0] = 8'h23; rom[1] = 8'h05; rom[2] = 8'h28; rom[3] = 8'hB0; rom[4] = 8'hA7;
    rom[5] = 8'h23; rom[6] = 8'h3C; rom[7] = 8'h30; rom[8] = 8'h20; rom[9] = 8'h20;
    rom[10] = 8'hD5; rom[11] = 8'h2B; rom[12] = 8'hC5; rom[13] = 8'h2B;
    restart();
    step(3);
    compare({4'h0, acc}, 12'h000);
    step(2);
    compare(pc, 12'h005);
    step(3);
    compare({4'h0, acc}, 12'h037);
    compare(pc, 12'h008);
    step(1);
    compare({4'h0, acc}, 12'h0AC);
    step(1);
    compare({4'h0, acc}, 12'h037);
    // Bank 1 R3 takes 0x37 and hands back 0; bank 0 R3 is still 0
    step(4);
    compare({4'h0, acc}, 12'h000);
  endtask : test_exchange
  // Lookups from the current page and from the fixed page
  task automatic test_lookup();
    clear_rom();
    rom[0] = 8'h23; rom[1] = 8'h10; rom[2] = 8'hA3; rom[3] = 8'h23; rom[4] = 8'h20;
    rom[5] = 8'hE3; rom[12'h010] = 8'h5A; rom[12'h320] = 8'hC3; rom[12'h020] = 8'h99;
    restart();
    step(3);
    compare({4'h0, acc}, 12'h010);
    compare(rom_addr, 12'h010);
    step(1);
    compare({4'h0, acc}, 12'h05A);
    compare(pc, 12'h003);
    step(3);
    compare(rom_addr, 12'h320);
    step(1);
    compare({4'h0, acc}, 12'h0C3);
    compare(pc, 12'h006);
  endtask : test_lookup
  // Host buffer flags and the status nibble
  task automatic test_host();
    clear_rom();
    rom[0] = 8'h23; rom[1] = 8'hF5; rom[2] = 8'h90; rom[3] = 8'h22; rom[4] = 8'h02;
    restart();
    host.send(8'h6B);
    compare({11'h000, input_full_flag}, 12'h001);
    step(2);
    compare({4'h0, host_status_register}, 12'h0F2);
    step(1);
    compare({3'h0, input_full_flag, acc}, 12'h06B);
    compare({4'h0, host_status_register}, 12'h0F0);
    step(1);
    compare({3'h0, output_full_flag, host_rdata}, 12'h16B);
    compare({4'h0, host_status_register}, 12'h0F1);
    host.take(got);
    compare({3'h0, output_full_flag, got}, 12'h06B);
  endtask : test_host
  // Timer overflow, interrupt enable and disable, branch taken and not taken
  task automatic test_timer();
    clear_rom();
    rom[0] = 8'h23; rom[1] = 8'hFF; rom[2] = 8'h62; rom[3] = 8'h55; rom[4] = 8'h25;
    rom[12'h040] = 8'h16; rom[12'h041] = 8'h80; rom[12'h080] = 8'h16; rom[12'h081] = 8'hC0;
    rom[12'h082] = 8'h35; rom[12'h083] = 8'h23; rom[12'h084] = 8'hFF; rom[12'h085] = 8'h62;
    restart();
    step(5);
    n = 0;
    while (timer_flag !== 1'b1 && n < 60)
    begin
      step(1);
      n++;
    end
    compare({10'h000, timer_flag, timer_count_interrupt}, 12'h003);
    n = 0;
    while (pc !== 12'h080 && pc !== 12'h042 && n < 80)
    begin
      step(1);
      n++;
    end
    compare(pc, 12'h080);
    compare({11'h000, timer_flag}, 12'h000);
    step(2);
    compare(pc, 12'h082);
    step(4);
    compare({4'h0, timer_value}, 12'h0FF);
    n = 0;
    while (timer_flag !== 1'b1 && n < 40)
    begin
      step(1);
      n++;
    end
    compare({10'h000, timer_flag, timer_count_interrupt}, 12'h002);
  endtask : test_timer
  // Counter mode counts pin falls until stopped
  task automatic test_counter();
    clear_rom();
    rom[0] = 8'h45; rom[12'h020] = 8'h42; rom[12'h021] = 8'h65; rom[12'h030] = 8'h42;
    restart();
    for (int r = 0; r < 5; r++)
    begin
      step(2);
      t1_pin = 1'b0;
      step(2);
      t1_pin = 1'b1;
      if (r == 2)
        step(32 - 13);
    end
    // The second timer read at 0x30 comes after the stop and two more pin falls
    step(10);
    compare({4'h0, acc}, 12'h003);
    compare({4'h0, timer_value}, 12'h003);
  endtask : test_counter
  // Suspend completes after two cycles and nothing runs afterwards
  task automatic test_suspend();
    clear_rom();
    rom[0] = 8'h82; rom[1] = 8'h23; rom[2] = 8'h55;
    restart();
    step(1);
    compare({11'h000, suspended}, 12'h000);
    step(1);
    compare({11'h000, suspended}, 12'h001);
    step(4);
    compare({3'h0, suspended, acc}, 12'h100);
  endtask : test_suspend
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    t1_pin = 1'b1;
    clear_rom();
    step(4);
    // The first restart gives the fifth reset cycle
    test_rotate();
    test_exchange();
    test_lookup();
    test_host();
    test_timer();
    test_counter();
    test_suspend();
    stop_test();
  end
  // Whole run is well under a thousand cycles; this cuts a hang short
  initial
  begin
    #50000;
    mismatches++;
    stop_test();
  end
endmodule : slave_mcu_instruction_execution_bench
